/* File: core/frs_pkg.sv */
// Constants, types and register map of the field reversal sequencer
package frs_pkg;
  // Clock and timebase
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int BRAKE_MS = 30;
  localparam int BRAKE_CYC = CLK_HZ / 1000 * BRAKE_MS;
  // Widths
  localparam int AW = 4;
  localparam int DW = 16;
  localparam int WW = 10;
  localparam int NWAIT = 5;
  // Register offsets
  localparam logic [AW-1:0] OFS_WAIT0 = 4'h0;
  localparam logic [AW-1:0] OFS_FIELD_MIN = 4'h5;
  localparam logic [AW-1:0] OFS_READY_FACTOR = 4'h6;
  localparam logic [AW-1:0] OFS_MIN_SPEED = 4'h7;
  localparam logic [AW-1:0] OFS_SPEED_SEL = 4'h8;
  localparam logic [AW-1:0] OFS_STATUS = 4'h9;
  // Reset values, wait times in 10 ms units
  localparam logic [WW-1:0] RST_WAIT0 = 10'h12C;
  localparam logic [WW-1:0] RST_WAIT1 = 10'h014;
  localparam logic [WW-1:0] RST_WAIT2 = 10'h00A;
  localparam logic [WW-1:0] RST_WAIT3 = 10'h12C;
  localparam logic [WW-1:0] RST_WAIT4 = 10'h12C;
  localparam logic [WW-1:0] WAIT_MAX = 10'h3E8;
  localparam logic [DW-1:0] RST_FIELD_MIN = 16'h0100;
  localparam logic [7:0] RST_READY_FACTOR = 8'hE6;
  localparam logic [DW-1:0] RST_MIN_SPEED = 16'h0040;
  localparam logic [3:0] RST_SPEED_SEL = 4'h0;
  localparam logic [3:0] SPEED_SEL_EMF = 4'h3;
  // Contactor command codes
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_POS = 2'h1;
  localparam logic [1:0] CMD_NEG = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ARM_ZERO = 4'h1,
    ST_FLD_DECAY = 4'h2,
    ST_WAIT_OPEN = 4'h3,
    ST_WAIT_CLOSE = 4'h4,
    ST_WAIT_FENA = 4'h5,
    ST_FLD_RISE = 4'h6,
    ST_WAIT_AENA = 4'h7,
    ST_BRK_RAMP = 4'h8,
    ST_BRK_AZERO = 4'h9,
    ST_BRK_HOLD = 4'hA,
    ST_BRK_STOP = 4'hB,
    ST_BRK_ACK = 4'hC
  } frs_state_t;

  typedef enum logic [1:0] {
    MODE_DIR = 2'h0,
    MODE_BRAKE = 2'h1,
    MODE_RESTORE = 2'h2
  } frs_mode_t;

  typedef struct packed {
    logic braking;
    logic field_neg;
    logic fld_en;
    logic arm_en;
    logic [1:0] cmd;
    frs_mode_t mode;
    frs_state_t state;
  } frs_status_t;
endpackage

/* File: core/frs_sequencer.sv */
// Field reversal sequencer: direction reversal and braking by field reversal
`timescale 1ns/100ps
module frs_sequencer
  import frs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int BRAKE_CYCLES = BRAKE_CYC
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DW-1:0] rd_data_out,
  // Control inputs
  input wire logic direction_select_in,
  input wire logic brake_request_in,
  input wire logic line_contactor_closed_in,
  input wire logic stop_cmd_in,
  input wire logic switch_on_cmd_in,
  // Measured values
  input wire logic armature_current_zero_in,
  input wire logic [DW-1:0] field_current_actual_in,
  input wire logic [DW-1:0] field_current_setpoint_in,
  input wire logic signed [DW-1:0] speed_actual_in,
  // Contactors and firing gates
  output logic [1:0] field_contactor_cmd_out,
  output logic arm_pulse_en_out,
  output logic field_pulse_en_out,
  // Speed path and drive state
  output logic signed [DW-1:0] speed_internal_out,
  output logic ramp_zero_set_out,
  output logic braking_out,
  output logic wait_pulse_enable_state_out,
  output logic braked_stop_state_out
);

  frs_state_t state_q;
  frs_state_t state_d;
  frs_mode_t mode_q;
  frs_mode_t mode_d;
  logic [WW-1:0] wait_time_q [NWAIT];
  logic [DW-1:0] field_min_q;
  logic [7:0] ready_factor_q;
  logic [DW-1:0] min_speed_q;
  logic [3:0] speed_sel_q;
  logic field_neg_q;
  logic [17:0] tick_cnt_q;
  logic tick_q;
  logic [WW-1:0] wait_cnt_q;
  logic wait_load;
  logic [WW-1:0] wait_value;
  logic wait_done;
  logic [19:0] brake_cnt_q;
  logic brake_held_q;
  logic speed_invert;
  logic signed [DW:0] speed_int_wide;
  logic [DW:0] speed_abs;
  logic [23:0] field_ready_level;
  logic field_low;
  logic field_ready;
  frs_status_t status;

  // Configuration registers
  genvar gi;
  generate
    for (gi = 0; gi < NWAIT; gi++)
    begin : g_wait_reg
      localparam logic [AW-1:0] OFS = OFS_WAIT0 + AW'(gi);
      localparam logic [WW-1:0] RST = (gi == 0) ? RST_WAIT0 :
                                     (gi == 1) ? RST_WAIT1 :
                                     (gi == 2) ? RST_WAIT2 :
                                     (gi == 3) ? RST_WAIT3 : RST_WAIT4;
      always_ff @(posedge ref_clk_in or posedge rst_in)
      begin
        if (rst_in)
          wait_time_q[gi] <= RST;
        else if (wr_in && addr_in == OFS)
        begin
          // Clamp to the 10.0 s range
          if (wr_data_in > DW'(WAIT_MAX))
            wait_time_q[gi] <= WAIT_MAX;
          else
            wait_time_q[gi] <= wr_data_in[WW-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      field_min_q <= RST_FIELD_MIN;
      ready_factor_q <= RST_READY_FACTOR;
      min_speed_q <= RST_MIN_SPEED;
      speed_sel_q <= RST_SPEED_SEL;
    end
    else if (wr_in)
    begin
      case (addr_in)
        OFS_FIELD_MIN: field_min_q <= wr_data_in;
        OFS_READY_FACTOR: ready_factor_q <= wr_data_in[7:0];
        OFS_MIN_SPEED: min_speed_q <= wr_data_in;
        OFS_SPEED_SEL: speed_sel_q <= wr_data_in[3:0];
        default: ;
      endcase
    end
  end

  // Read port, data valid in the cycle after the strobe
  always_comb
  begin
    status.braking = braking_out;
    status.field_neg = field_neg_q;
    status.fld_en = field_pulse_en_out;
    status.arm_en = arm_pulse_en_out;
    status.cmd = field_contactor_cmd_out;
    status.mode = mode_q;
    status.state = state_q;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rd_data_out <= 16'h0000;
    else if (rd_in)
    begin
      if (addr_in < OFS_FIELD_MIN)
        rd_data_out <= DW'(wait_time_q[addr_in[2:0]]);
      else
        case (addr_in)
          OFS_FIELD_MIN: rd_data_out <= field_min_q;
          OFS_READY_FACTOR: rd_data_out <= {8'h00, ready_factor_q};
          OFS_MIN_SPEED: rd_data_out <= min_speed_q;
          OFS_SPEED_SEL: rd_data_out <= {12'h000, speed_sel_q};
          OFS_STATUS: rd_data_out <= DW'(status);
          default: rd_data_out <= 16'h0000;
        endcase
    end
    else
      rd_data_out <= 16'h0000;
  end

  // Timebase tick
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tick_cnt_q <= 18'h00000;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == 18'(TICK_CYCLES - 1))
    begin
      tick_cnt_q <= 18'h00000;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 18'h00001;
      tick_q <= 1'b0;
    end
  end

  // Step delay counter
  always_comb
  begin
    wait_load = (state_d != state_q) &&
                (state_d == ST_WAIT_OPEN || state_d == ST_WAIT_CLOSE ||
                 state_d == ST_WAIT_FENA || state_d == ST_WAIT_AENA);
    case (state_d)
      ST_WAIT_OPEN: wait_value = wait_time_q[0];
      ST_WAIT_CLOSE: wait_value = wait_time_q[1];
      ST_WAIT_FENA: wait_value = wait_time_q[2];
      default: wait_value = (mode_d == MODE_RESTORE) ? wait_time_q[4] : wait_time_q[3];
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      wait_cnt_q <= 10'h000;
    else if (wait_load)
      wait_cnt_q <= (wait_value == 10'h000) ? 10'h000 : wait_value + 10'h001;
    else if (tick_q && wait_cnt_q != 10'h000)
      wait_cnt_q <= wait_cnt_q - 10'h001;
  end

  assign wait_done = (wait_cnt_q == 10'h000);

  // Braking button qualification
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      brake_cnt_q <= 20'h00000;
      brake_held_q <= 1'b0;
    end
    else if (!brake_request_in || !line_contactor_closed_in)
    begin
      brake_cnt_q <= 20'h00000;
      brake_held_q <= 1'b0;
    end
    else if (brake_cnt_q == 20'(BRAKE_CYCLES - 1))
      brake_held_q <= 1'b1;
    else
      brake_cnt_q <= brake_cnt_q + 20'h00001;
  end

  // Current and speed comparisons
  assign field_low = field_current_actual_in < field_min_q;
  assign field_ready_level = field_current_setpoint_in * ready_factor_q;
  assign field_ready = {field_current_actual_in, 8'h00} > field_ready_level;
  assign speed_invert = field_neg_q && (speed_sel_q != SPEED_SEL_EMF);
  assign speed_int_wide = speed_invert ? -(DW+1)'(speed_actual_in) : (DW+1)'(speed_actual_in);
  assign speed_abs = speed_int_wide[DW] ? (DW+1)'(-speed_int_wide) : speed_int_wide;

  // Sequencer
  always_comb
  begin
    state_d = state_q;
    mode_d = mode_q;
    case (state_q)
      ST_IDLE:
      begin
        if (brake_held_q && line_contactor_closed_in)
        begin
          state_d = ST_ARM_ZERO;
          mode_d = MODE_BRAKE;
        end
        else if (!brake_held_q && direction_select_in != field_neg_q)
        begin
          state_d = ST_ARM_ZERO;
          mode_d = MODE_DIR;
        end
      end
      ST_ARM_ZERO:
        if (armature_current_zero_in)
          state_d = ST_FLD_DECAY;
      ST_FLD_DECAY:
        if (field_low)
          state_d = ST_WAIT_OPEN;
      ST_WAIT_OPEN:
        if (wait_done)
          state_d = ST_WAIT_CLOSE;
      ST_WAIT_CLOSE:
        if (wait_done)
          state_d = ST_WAIT_FENA;
      ST_WAIT_FENA:
        if (wait_done)
          state_d = ST_FLD_RISE;
      ST_FLD_RISE:
        if (field_ready)
          state_d = ST_WAIT_AENA;
      ST_WAIT_AENA:
        if (wait_done)
        begin
          case (mode_q)
            MODE_BRAKE: state_d = ST_BRK_RAMP;
            MODE_RESTORE: state_d = ST_BRK_STOP;
            default: state_d = ST_IDLE;
          endcase
        end
      ST_BRK_RAMP:
        if (speed_abs < {1'b0, min_speed_q})
          state_d = ST_BRK_AZERO;
      ST_BRK_AZERO:
        if (armature_current_zero_in)
          state_d = ST_BRK_HOLD;
      ST_BRK_HOLD:
        if (!brake_request_in)
        begin
          if (direction_select_in != field_neg_q)
          begin
            state_d = ST_ARM_ZERO;
            mode_d = MODE_RESTORE;
          end
          else
            state_d = ST_BRK_STOP;
        end
      ST_BRK_STOP:
        if (stop_cmd_in)
          state_d = ST_BRK_ACK;
      ST_BRK_ACK:
        if (switch_on_cmd_in)
        begin
          state_d = ST_IDLE;
          mode_d = MODE_DIR;
        end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_IDLE;
      mode_q <= MODE_DIR;
    end
    else
    begin
      state_q <= state_d;
      mode_q <= mode_d;
    end
  end

  // Field direction and contactor commands
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      field_neg_q <= 1'b0;
      field_contactor_cmd_out <= CMD_POS;
    end
    else if (state_q == ST_WAIT_OPEN && state_d == ST_WAIT_CLOSE)
      field_contactor_cmd_out <= CMD_NONE;
    else if (state_q == ST_WAIT_CLOSE && state_d == ST_WAIT_FENA)
    begin
      field_neg_q <= ~field_neg_q;
      field_contactor_cmd_out <= field_neg_q ? CMD_POS : CMD_NEG;
    end
  end

  // Firing gates and drive states
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      arm_pulse_en_out <= 1'b1;
      field_pulse_en_out <= 1'b1;
      ramp_zero_set_out <= 1'b0;
      wait_pulse_enable_state_out <= 1'b0;
      braked_stop_state_out <= 1'b0;
    end
    else
    begin
      arm_pulse_en_out <= (state_d == ST_IDLE || state_d == ST_BRK_RAMP ||
                           (state_d == ST_ARM_ZERO && mode_d != MODE_RESTORE) ||
                           state_d == ST_BRK_AZERO);
      field_pulse_en_out <= !(state_d == ST_FLD_DECAY || state_d == ST_WAIT_OPEN ||
                              state_d == ST_WAIT_CLOSE ||
                              state_d == ST_WAIT_FENA);
      ramp_zero_set_out <= (state_d == ST_BRK_RAMP);
      wait_pulse_enable_state_out <= (mode_d != MODE_RESTORE) &&
                                     (state_d >= ST_FLD_DECAY) &&
                                     (state_d <= ST_WAIT_AENA);
      braked_stop_state_out <= (state_d >= ST_BRK_HOLD) ||
                               (mode_d == MODE_RESTORE && state_d != ST_IDLE);
    end
  end

  // Internal speed actual value
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      speed_internal_out <= 16'sh0000;
      braking_out <= 1'b0;
    end
    else
    begin
      speed_internal_out <= speed_int_wide[DW-1:0];
      braking_out <= (mode_q == MODE_BRAKE) && speed_int_wide[DW] &&
                     (state_q == ST_WAIT_AENA || state_q == ST_BRK_RAMP);
    end
  end

endmodule // frs_sequencer

/* File: testbench/frs_sequencer_properties.sv */
// Port-level checks for the field reversal sequencer
`timescale 1ns/100ps
module frs_sequencer_checker
  import frs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Watched inputs
  input wire logic brake_request_in,
  input wire logic switch_on_cmd_in,
  input wire logic armature_current_zero_in,
  // Watched outputs
  input wire logic [1:0] field_contactor_cmd_out,
  input wire logic arm_pulse_en_out,
  input wire logic field_pulse_en_out,
  input wire logic ramp_zero_set_out,
  input wire logic wait_pulse_enable_state_out,
  input wire logic braked_stop_state_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_cmd_moved;
    $changed(field_contactor_cmd_out);
  endsequence
  sequence s_cmd_left_closed;
    $changed(field_contactor_cmd_out) && $past(field_contactor_cmd_out) != CMD_NONE;
  endsequence
  property p_cmd_exclusive;
    field_contactor_cmd_out != 2'h3;
  endproperty
  property p_break_first;
    s_cmd_left_closed |-> field_contactor_cmd_out == CMD_NONE;
  endproperty
  property p_switch_field_off;
    s_cmd_moved |-> !field_pulse_en_out;
  endproperty
  property p_wait_arm_off;
    wait_pulse_enable_state_out |-> !arm_pulse_en_out;
  endproperty
  property p_arm_drop_at_zero;
    $fell(arm_pulse_en_out) |-> $past(armature_current_zero_in);
  endproperty
  property p_field_on_after_close;
    $rose(field_pulse_en_out) |-> field_contactor_cmd_out != CMD_NONE
      && $stable(field_contactor_cmd_out);
  endproperty
  property p_stop_arm_off;
    $rose(braked_stop_state_out) |-> !arm_pulse_en_out;
  endproperty
  property p_stop_arm_held;
    braked_stop_state_out |-> !arm_pulse_en_out;
  endproperty
  property p_hold_pressed;
    $past(braked_stop_state_out) && $past(brake_request_in) |-> braked_stop_state_out;
  endproperty
  property p_leave_on_switch_on;
    $fell(braked_stop_state_out) |-> $past(switch_on_cmd_in);
  endproperty
  property p_ramp_zero_start;
    $rose(ramp_zero_set_out) |-> arm_pulse_en_out && !wait_pulse_enable_state_out;
  endproperty
  a_cmd_exclusive: assert property (p_cmd_exclusive)
    else $error("both contactor commands set");
  a_break_first: assert property (p_break_first)
    else $error("contactor swapped without opening");
  a_switch_field_off: assert property (p_switch_field_off)
    else $error("contactor moved with field firing on");
  a_wait_arm_off: assert property (p_wait_arm_off)
    else $error("armature firing on in reversal wait");
  a_arm_drop_at_zero: assert property (p_arm_drop_at_zero)
    else $error("armature firing cut with current flowing");
  a_field_on_after_close: assert property (p_field_on_after_close)
    else $error("field firing on before contactor settled");
  a_stop_arm_off: assert property (p_stop_arm_off)
    else $error("braked stop with armature firing on");
  a_stop_arm_held: assert property (p_stop_arm_held)
    else $error("armature firing on in braked stop");
  a_hold_pressed: assert property (p_hold_pressed)
    else $error("braked stop left while button held");
  a_leave_on_switch_on: assert property (p_leave_on_switch_on)
    else $error("braked stop left without switch-on");
  a_ramp_zero_start: assert property (p_ramp_zero_start)
    else $error("zero ramp forced with armature blocked");
endmodule // frs_sequencer_checker

bind frs_sequencer frs_sequencer_checker frs_sequencer_checker_i (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .brake_request_in(brake_request_in),
  .switch_on_cmd_in(switch_on_cmd_in),
  .armature_current_zero_in(armature_current_zero_in),
  .field_contactor_cmd_out(field_contactor_cmd_out),
  .arm_pulse_en_out(arm_pulse_en_out),
  .field_pulse_en_out(field_pulse_en_out),
  .ramp_zero_set_out(ramp_zero_set_out),
  .wait_pulse_enable_state_out(wait_pulse_enable_state_out),
  .braked_stop_state_out(braked_stop_state_out)
);

/* File: testbench/frs_drive_model.sv */
// Field winding and armature current model for the sequencer bench
`timescale 1ns/100ps
module frs_drive_model
  import frs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Firing gates and bench load
  input wire logic field_pulse_en_in,
  input wire logic arm_pulse_en_in,
  input wire logic arm_load_in,
  // Measured values
  output logic [DW-1:0] field_current_actual_out,
  output logic armature_current_zero_out
);
  // Field current ramps slowly, so the decay and rise waits really wait
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      field_current_actual_out <= 16'h0000;
    else if (field_pulse_en_in && field_current_actual_out < 16'h0800)
      field_current_actual_out <= field_current_actual_out + 16'h0040;
    else if (!field_pulse_en_in && field_current_actual_out != 16'h0000)
      field_current_actual_out <= field_current_actual_out - 16'h0040;
  end
  assign armature_current_zero_out = !(arm_pulse_en_in && arm_load_in);
endmodule // frs_drive_model

/* File: testbench/frs_sequencer_tb.sv */
// Self-checking bench for the field reversal sequencer
`timescale 1ns/100ps
module frs_sequencer_tb
  import frs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] addr = 4'h0;
  logic [DW-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic dir = 1'b0;
  logic brake = 1'b0;
  logic line_closed = 1'b0;
  logic stop_cmd = 1'b0;
  logic switch_on = 1'b0;
  logic arm_load = 1'b1;
  logic signed [DW-1:0] speed = 16'sh0100;
  logic [DW-1:0] rdata;
  logic [DW-1:0] fld_cur;
  logic signed [DW-1:0] spd_int;
  logic [1:0] cmd;
  logic arm_en, fld_en, arm_zero, ramp_zero, braking, wait_pe, brk_stop;
  int err_count = 0;
  int comparisons = 0;

  frs_sequencer #(.TICK_CYCLES(20), .BRAKE_CYCLES(30)) frs_sequencer_i (
    .ref_clk_in(clk), .rst_in(rst), .addr_in(addr), .wr_data_in(wdata), .wr_in(wr),
    .rd_in(rd), .rd_data_out(rdata), .direction_select_in(dir), .brake_request_in(brake),
    .line_contactor_closed_in(line_closed), .stop_cmd_in(stop_cmd),
    .switch_on_cmd_in(switch_on), .armature_current_zero_in(arm_zero),
    .field_current_actual_in(fld_cur), .field_current_setpoint_in(16'h0800),
    .speed_actual_in(speed), .field_contactor_cmd_out(cmd), .arm_pulse_en_out(arm_en),
    .field_pulse_en_out(fld_en), .speed_internal_out(spd_int),
    .ramp_zero_set_out(ramp_zero), .braking_out(braking),
    .wait_pulse_enable_state_out(wait_pe), .braked_stop_state_out(brk_stop));
  frs_drive_model frs_drive_model_i (
    .ref_clk_in(clk), .rst_in(rst), .field_pulse_en_in(fld_en), .arm_pulse_en_in(arm_en),
    .arm_load_in(arm_load), .field_current_actual_out(fld_cur),
    .armature_current_zero_out(arm_zero));

  initial
  begin
    forever #25 clk = ~clk;
  end

  task automatic print_verdict();
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic reg_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic t_regs();
    logic [DW-1:0] tab [9];
    tab = '{16'h012C, 16'h0014, 16'h000A, 16'h012C, 16'h012C, 16'h0100, 16'h00E6,
      16'h0040, 16'h0000};
    for (int i = 0; i < 9; i++)
      reg_rd(4'(i), tab[i]);
    reg_rd(4'hF, 16'h0000);
    reg_wr(OFS_STATUS, 16'hFFFF);
    reg_rd(OFS_STATUS, 16'h0340);
    reg_wr(OFS_WAIT0, 16'h07D0);
    reg_rd(OFS_WAIT0, 16'(WAIT_MAX));
    reg_wr(OFS_WAIT0, 16'h0001);
    reg_wr(4'h1, 16'h0003);
    reg_wr(4'h2, 16'h0001);
    reg_wr(4'h3, 16'h0001);
    reg_wr(4'h4, 16'h0001);
  endtask

  task automatic t_dir();
    int n;
    reg_wr(OFS_SPEED_SEL, 16'h0003);
    @(posedge clk);
    dir <= 1'b1;
    tick(40);
    reg_rd(OFS_STATUS, 16'h0341);
    @(posedge clk);
    dir <= 1'b0;
    arm_load <= 1'b0;
    tick(5);
    chk(16'({wait_pe, arm_en, fld_en}), 16'h0004);
    @(posedge clk);
    dir <= 1'b1;
    for (n = 0; n < 3000 && cmd !== CMD_NONE; n++) tick(1);
    for (n = 0; n < 200 && cmd === CMD_NONE; n++) tick(1);
    chk(16'(n >= 60 && n <= 81), 16'h0001);
    chk(16'(cmd), 16'(CMD_NEG));
    for (n = 0; n < 3000 && arm_en !== 1'b1; n++) tick(1);
    chk(16'({wait_pe, fld_en}), 16'h0001);
    chk(spd_int, 16'h0100);
    reg_wr(OFS_SPEED_SEL, 16'h0000);
    tick(3);
    chk(spd_int, 16'hFF00);
  endtask

  task automatic t_brake();
    @(posedge clk);
    brake <= 1'b1;
    speed <= -16'sh0100;
    tick(60);
    chk(16'(wait_pe), 16'h0000);
    @(posedge clk);
    brake <= 1'b0;
    line_closed <= 1'b1;
    tick(2);
    @(posedge clk);
    brake <= 1'b1;
    tick(20);
    @(posedge clk);
    brake <= 1'b0;
    tick(20);
    chk(16'(wait_pe), 16'h0000);
    @(posedge clk);
    brake <= 1'b1;
    for (int i = 0; i < 4000 && ramp_zero !== 1'b1; i++) tick(1);
    chk(16'({ramp_zero, braking, arm_en}), 16'h0007);
    chk(16'(cmd), 16'(CMD_POS));
    @(posedge clk);
    arm_load <= 1'b1;
    speed <= 16'sh0000;
    tick(40);
    chk(16'(brk_stop), 16'h0000);
    @(posedge clk);
    arm_load <= 1'b0;
    tick(100);
    chk(16'({brk_stop, arm_en}), 16'h0002);
    @(posedge clk);
    brake <= 1'b0;
    tick(600);
    chk(16'({cmd, brk_stop}), 16'h0005);
    @(posedge clk);
    switch_on <= 1'b1;
    @(posedge clk);
    switch_on <= 1'b0;
    tick(5);
    chk(16'(brk_stop), 16'h0001);
    @(posedge clk);
    stop_cmd <= 1'b1;
    @(posedge clk);
    stop_cmd <= 1'b0;
    switch_on <= 1'b1;
    @(posedge clk);
    switch_on <= 1'b0;
    tick(5);
    chk(16'({brk_stop, arm_en}), 16'h0001);
  endtask

  initial
  begin
    #(20000 * 50);
    err_count++;
    print_verdict();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_dir();
    t_brake();
    print_verdict();
  end
endmodule // frs_sequencer_tb
